// ### design/limit_defines.svh
`ifndef LIMIT_DEFINES_SVH
`define LIMIT_DEFINES_SVH

// channel population
`define NUM_CHAN         9
`define FIRST_TEMP_CHAN  6
`define NUM_DIODE        2

// register address map
`define ADDR_STATUS_A    8'h04
`define ADDR_STATUS_B    8'h05
`define ADDR_STATUS_C    8'h06
`define ADDR_CHAN_TOP    2'h1
`define KIND_UPPER       2'h0
`define KIND_LOWER       2'h1
`define KIND_HYST        2'h2

// reset values
`define UPPER_RESET      12'hFFF
`define LOWER_RESET      12'h000
`define HYST_RESET_VOLT  16'h0008
`define HYST_RESET_TEMP  16'h0020

// field positions and codes
`define RECORDER_CODE    12'hFFF
`define DIODE_FLAG_BIT   11
`define OVR_BIT          4
`define OPEN_DIODE_BIT   7

`endif

// ### design/limit_pkg.sv
package limit_pkg;
    typedef logic [11:0] code_t;
    typedef logic [15:0] word_t;
    typedef enum logic [2:0] {
        regNone, regUpper, regLower, regHyst, regStatA, regStatB, regStatC
    } reg_kind_t;
    typedef struct packed {
        reg_kind_t  kind;
        logic [3:0] chan;
    } reg_sel_t;
endpackage

// ### design/limit_eval_if.sv
`timescale 1ns/1ps
interface limit_eval_if;
    limit_pkg::code_t result;
    limit_pkg::code_t upper;
    limit_pkg::code_t lower;
    limit_pkg::code_t hystN;
    logic             highNow;
    logic             lowNow;
    logic             highNext;
    logic             lowNext;
    limit_pkg::code_t upperNext;
    limit_pkg::code_t lowerNext;
    logic             recorder;

    modport top  (output result, upper, lower, hystN, highNow, lowNow,
                  input highNext, lowNext, upperNext, lowerNext, recorder);
    modport eval (input result, upper, lower, hystN, highNow, lowNow,
                  output highNext, lowNext, upperNext, lowerNext, recorder);
endinterface

// ### design/limit_eval.sv
`timescale 1ns/1ps
`include "limit_defines.svh"
module limit_eval (
    limit_eval_if.eval ev
);
    logic [12:0] highRelease;
    logic [12:0] lowRelease;

    // 13-bit sums so a large margin cannot wrap into a false release
    assign highRelease = {1'b0, ev.result} + {1'b0, ev.hystN}; // R8
    assign lowRelease  = {1'b0, ev.lower} + {1'b0, ev.hystN};

    always_comb
    begin
        ev.recorder  = (ev.hystN == `RECORDER_CODE); // R12
        ev.upperNext = ev.upper;
        ev.lowerNext = ev.lower;
        ev.highNext  = 1'b0;
        ev.lowNext   = 1'b0;
        if (ev.recorder)
        begin
            // recorder mode raises nothing
            if (ev.result > ev.upper)
                ev.upperNext = ev.result; // R16
            if (ev.result < ev.lower)
                ev.lowerNext = ev.result; // R16
        end
        else
        begin
            // a zero margin reduces to plain in-range clearing
            ev.highNext = (ev.result > ev.upper) // R1
                | (ev.highNow & (highRelease > {1'b0, ev.upper})); // R6
            ev.lowNext = (ev.result < ev.lower) // R2
                | (ev.lowNow & ({1'b0, ev.result} < lowRelease)); // R6
        end
    end
endmodule

// ### design/adc_limit_checker.sv
// Overview of operation
// R1: result above its upper limit raises that channel's upper alert.
// R2: result below its lower limit raises that channel's lower alert.
// R3: alerts drive the alert pin, the result flag, or both, per enables.
// R4: limit alerts clear by themselves once a result is back in range.
// R5: status is re-evaluated after every conversion, about every 50 us.
// R6: clearing needs the result N codes inside the limit, N per channel.
// R7: each channel has one hysteresis register serving both its limits.
// R8: a margin near full scale means alerts practically never self-clear.
// R9: bit 11 of diode channel limits reads 0 when the diode is open.
// R10: overrange alerts stay latched until the host clears them.
// R11: hysteresis resets to 8 codes, 32 codes on temperature channels.
// R12: hysteresis of all ones turns limits into a min/max recorder.
// R13: upper limits reset to full scale, lower limits to zero.
// R14: two status bits per channel, violations on channels accumulate.
// R15: host clears a status byte with all ones, or single bits.
// R16: recorder channels raise no alerts, keep only new extremes.
`timescale 1ns/1ps
`include "limit_defines.svh"
module adc_limit_checker (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             convValid,
    input  wire logic [3:0]       convChannel,
    input  wire logic [11:0]      convResult,
    input  wire logic             alertPinEnable,
    input  wire logic             alertFlagEnable,
    input  wire logic [1:0]       currentOverrangeInput,
    input  wire logic [1:0]       diodeOpenInput,
    input  wire logic             regWrite,
    input  wire logic [7:0]       regAddr,
    input  wire logic [15:0]      regWrData,
    output logic      [15:0]      regRdData,
    output logic                  alertPin,
    output logic                  alertFlag
);
    ////////////////////////////////////////////////////////////////////////
    limit_pkg::code_t             upperReg [`NUM_CHAN];
    limit_pkg::code_t             upperNext [`NUM_CHAN];
    limit_pkg::code_t             lowerReg [`NUM_CHAN];
    limit_pkg::code_t             lowerNext [`NUM_CHAN];
    limit_pkg::word_t             hystReg [`NUM_CHAN];
    limit_pkg::word_t             hystNext [`NUM_CHAN];
    logic [`NUM_CHAN-1:0]         highReg;
    logic [`NUM_CHAN-1:0]         highNext;
    logic [`NUM_CHAN-1:0]         lowReg;
    logic [`NUM_CHAN-1:0]         lowNext;
    logic [1:0]                   ovrReg;
    logic [1:0]                   ovrNext;
    logic                         openReg;
    logic                         openNext;
    logic [1:0]                   ovrMeta;
    logic [1:0]                   ovrSync;
    logic [1:0]                   diodeMeta;
    logic [1:0]                   diodeSync;
    logic [15:0]                  rdReg;
    logic [15:0]                  rdNext;
    logic                         alertPinReg;
    logic                         alertPinNext;
    logic                         alertFlagReg;
    logic                         alertFlagNext;
    logic                         convHit;
    logic                         anyAlert;
    limit_pkg::reg_sel_t          sel;

    limit_eval_if ev ();

    limit_eval evalUnit (
        .ev (ev.eval)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic limit_pkg::reg_sel_t decodeAddr(input logic [7:0] a);
        limit_pkg::reg_sel_t s;
        s.kind = limit_pkg::regNone;
        s.chan = a[5:2];
        if (a == `ADDR_STATUS_A)
            s.kind = limit_pkg::regStatA;
        else if (a == `ADDR_STATUS_B)
            s.kind = limit_pkg::regStatB;
        else if (a == `ADDR_STATUS_C)
            s.kind = limit_pkg::regStatC;
        else if (a[7:6] == `ADDR_CHAN_TOP && a[5:2] < 4'(`NUM_CHAN))
        begin
            if (a[1:0] == `KIND_UPPER)
                s.kind = limit_pkg::regUpper;
            else if (a[1:0] == `KIND_LOWER)
                s.kind = limit_pkg::regLower;
            else if (a[1:0] == `KIND_HYST)
                s.kind = limit_pkg::regHyst;
        end
        return s;
    endfunction

    function automatic limit_pkg::reg_kind_t statusGroup(input int ch);
        if (ch < 4)
            return limit_pkg::regStatA;
        else if (ch < `FIRST_TEMP_CHAN)
            return limit_pkg::regStatB;
        return limit_pkg::regStatC;
    endfunction

    // lower alert sits at the even bit, upper alert just above it
    function automatic int statusPos(input int ch);
        if (ch < 4)
            return 2 * ch;
        else if (ch < `FIRST_TEMP_CHAN)
            return 2 * (ch - 4);
        return 2 * (ch - `FIRST_TEMP_CHAN);
    endfunction

    function automatic logic [7:0] packStatus(input int first,
                                              input int count,
                                              input logic [`NUM_CHAN-1:0] hi,
                                              input logic [`NUM_CHAN-1:0] lo);
        logic [7:0] b;
        b = 8'h00;
        for (int k = 0; k < count; k++)
        begin
            b[2*k]   = lo[first+k];
            b[2*k+1] = hi[first+k];
        end
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pins from the analog side are asynchronous to the clock
    always_ff @(posedge clock)
    begin
        ovrMeta   <= currentOverrangeInput;
        ovrSync   <= ovrMeta;
        diodeMeta <= diodeOpenInput;
        diodeSync <= diodeMeta;
    end

    assign sel     = decodeAddr(regAddr);
    assign convHit = convValid && (convChannel < 4'(`NUM_CHAN)); // R5

    // only the converted channel is fed to the evaluator
    always_comb
    begin
        ev.result  = convResult;
        ev.upper   = `UPPER_RESET;
        ev.lower   = `LOWER_RESET;
        ev.hystN   = 12'h000;
        ev.highNow = 1'b0;
        ev.lowNow  = 1'b0;
        if (convHit)
        begin
            ev.upper   = upperReg[convChannel];
            ev.lower   = lowerReg[convChannel];
            ev.hystN   = hystReg[convChannel][11:0]; // R7
            ev.highNow = highReg[convChannel];
            ev.lowNow  = lowReg[convChannel];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel state: limits, hysteresis, status bits
    always_comb
    begin
        for (int i = 0; i < `NUM_CHAN; i++)
        begin
            upperNext[i] = upperReg[i];
            lowerNext[i] = lowerReg[i];
            hystNext[i]  = hystReg[i];
            highNext[i]  = highReg[i];
            lowNext[i]   = lowReg[i];
            if (regWrite && sel.kind == statusGroup(i))
            begin
                if (regWrData[statusPos(i)+1])
                    highNext[i] = 1'b0; // R15
                if (regWrData[statusPos(i)])
                    lowNext[i] = 1'b0; // R15
            end
            // a conversion overrides a clear in the same cycle
            if (convHit && convChannel == 4'(i))
            begin
                highNext[i]  = ev.highNext; // R4
                lowNext[i]   = ev.lowNext; // R4
                upperNext[i] = ev.upperNext; // R12
                lowerNext[i] = ev.lowerNext; // R12
            end
            // host writes to limits win over recorder updates
            if (regWrite && sel.chan == 4'(i))
            begin
                if (sel.kind == limit_pkg::regUpper)
                    upperNext[i] = regWrData[11:0];
                if (sel.kind == limit_pkg::regLower)
                    lowerNext[i] = regWrData[11:0];
                if (sel.kind == limit_pkg::regHyst)
                    hystNext[i] = regWrData; // R11
            end
        end
    end

    always_ff @(posedge clock)
    begin
        for (int i = 0; i < `NUM_CHAN; i++)
        begin
            if (reset)
            begin
                upperReg[i] <= `UPPER_RESET; // R13
                lowerReg[i] <= `LOWER_RESET; // R13
                hystReg[i]  <= (i >= `FIRST_TEMP_CHAN) ? `HYST_RESET_TEMP
                                                       : `HYST_RESET_VOLT; // R11
            end
            else
            begin
                upperReg[i] <= upperNext[i];
                lowerReg[i] <= lowerNext[i];
                hystReg[i]  <= hystNext[i];
            end
        end
        if (reset)
        begin
            highReg <= '0;
            lowReg  <= '0;
        end
        else
        begin
            highReg <= highNext; // R14
            lowReg  <= lowNext; // R14
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // latched faults, set wins over a clear in the same cycle
    always_comb
    begin
        ovrNext  = ovrReg;
        openNext = openReg;
        if (regWrite && sel.kind == limit_pkg::regStatB)
            ovrNext = ovrReg & ~regWrData[`OVR_BIT+1:`OVR_BIT];
        if (regWrite && sel.kind == limit_pkg::regStatC
            && regWrData[`OPEN_DIODE_BIT])
            openNext = 1'b0;
        ovrNext  = ovrNext | ovrSync; // R10
        openNext = openNext | (|diodeSync);
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ovrReg  <= 2'h0;
            openReg <= 1'b0;
        end
        else
        begin
            ovrReg  <= ovrNext;
            openReg <= openNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs and read-back
    assign anyAlert = (|highReg) | (|lowReg) | (|ovrReg) | openReg;

    always_comb
    begin
        alertPinNext  = anyAlert & alertPinEnable; // R3
        alertFlagNext = anyAlert & alertFlagEnable; // R3
        rdNext        = 16'h0000;
        case (sel.kind)
            limit_pkg::regUpper: rdNext = {4'h0, upperReg[sel.chan]};
            limit_pkg::regLower: rdNext = {4'h0, lowerReg[sel.chan]};
            limit_pkg::regHyst:  rdNext = hystReg[sel.chan];
            limit_pkg::regStatA: rdNext = {8'h00,
                                           packStatus(0, 4, highReg, lowReg)};
            limit_pkg::regStatB: rdNext = {8'h00,
                packStatus(4, 2, highReg, lowReg)
                | {2'b00, ovrReg, 4'h0}};
            limit_pkg::regStatC: rdNext = {8'h00,
                packStatus(`FIRST_TEMP_CHAN, 3, highReg, lowReg)
                | {openReg, 7'h00}};
            default:             rdNext = 16'h0000;
        endcase
        // diode channels report the sensor state in the top code bit
        if ((sel.kind == limit_pkg::regUpper
             || sel.kind == limit_pkg::regLower)
            && sel.chan >= 4'(`FIRST_TEMP_CHAN)
            && sel.chan < 4'(`FIRST_TEMP_CHAN + `NUM_DIODE))
            rdNext[`DIODE_FLAG_BIT] =
                ~diodeSync[sel.chan[0]]; // R9
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            rdReg        <= 16'h0000;
            alertPinReg  <= 1'b0;
            alertFlagReg <= 1'b0;
        end
        else
        begin
            rdReg        <= rdNext;
            alertPinReg  <= alertPinNext;
            alertFlagReg <= alertFlagNext;
        end
    end

    assign regRdData = rdReg;
    assign alertPin  = alertPinReg;
    assign alertFlag = alertFlagReg;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence limitConv;
        convHit && !ev.recorder && !regWrite;
    endsequence

    sequence recordConv;
        convHit && ev.recorder && !regWrite;
    endsequence

    AST_UPPER_ALERT: assert property ( // R1
        limitConv and (convResult > ev.upper)
        |=> highReg[$past(convChannel)] ##1 (anyAlert && alertPinEnable)[*1]
            |=> alertPin)
        else $error("upper alert not raised");

    AST_LOWER_ALERT: assert property ( // R2
        limitConv and (convResult < ev.lower)
        |=> lowReg[$past(convChannel)])
        else $error("lower alert not raised");

    AST_FLAG_GATED: assert property ( // R3
        !alertFlagEnable |=> !alertFlag)
        else $error("flag set while disabled");

    AST_PIN_TRACKS: assert property ( // R3
        (anyAlert && alertPinEnable) ##1 1'b1 |-> alertPin)
        else $error("pin does not follow alerts");

    AST_HIGH_RELEASE: assert property ( // R6
        limitConv and ({1'b0, convResult} + {1'b0, ev.hystN}
                       <= {1'b0, ev.upper})
        |=> !highReg[$past(convChannel)])
        else $error("upper alert not released");

    AST_HIGH_HOLDS: assert property ( // R6
        limitConv and ev.highNow and (convResult <= ev.upper)
        and ({1'b0, convResult} + {1'b0, ev.hystN}
             > {1'b0, ev.upper})
        |=> highReg[$past(convChannel)])
        else $error("upper alert released inside margin");

    AST_OVR_LATCHED: assert property ( // R10
        ovrReg[0] && !(regWrite && sel.kind == limit_pkg::regStatB)
        |=> ovrReg[0] [*2] or (ovrReg[0] ##1
            (regWrite && sel.kind == limit_pkg::regStatB)))
        else $error("overrange alert lost");

    AST_RECORD_MAX: assert property ( // R16
        recordConv and (convResult > ev.upper)
        |=> upperReg[$past(convChannel)] == $past(convResult)
            && !highReg[$past(convChannel)])
        else $error("maximum not recorded");

    AST_RESET_LOAD: assert property ( // R11
        $past(reset) |-> hystReg[0] == `HYST_RESET_VOLT
            && hystReg[`FIRST_TEMP_CHAN] == `HYST_RESET_TEMP
            && upperReg[0] == `UPPER_RESET && lowerReg[0] == `LOWER_RESET)
        else $error("wrong power-up contents");

    AST_CLEAR_A: assert property ( // R15
        regWrite && sel.kind == limit_pkg::regStatA
        && regWrData[7:0] == 8'hFF && !convHit
        |=> highReg[3:0] == 4'h0 && lowReg[3:0] == 4'h0)
        else $error("status byte not cleared");

    AST_DIODE_FLAG: assert property ( // R9
        sel.kind == limit_pkg::regUpper
        && sel.chan == 4'(`FIRST_TEMP_CHAN)
        |=> regRdData[`DIODE_FLAG_BIT] == !$past(diodeSync[0]))
        else $error("diode flag misreported");
endmodule

// ### verification/limit_host.sv
`timescale 1ns/1ps
module limit_host #(
    parameter int DRIVE = 5
) (
    input  wire logic        clock,
    output logic             regWrite,
    output logic [7:0]       regAddr,
    output logic [15:0]      regWrData,
    input  wire logic [15:0] regRdData
);
    ////////////////////////////////////////////////////////////
    initial
    begin
        regWrite  = 1'b0;
        regAddr   = 8'h00;
        regWrData = 16'h0000;
    end

    ////////////////////////////////////////////////////////////
    // a clock edge always lies between two strobes
    task automatic writeReg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        #DRIVE;
        regWrite  = 1'b1;
        regAddr   = a;
        regWrData = d;
        @(posedge clock);
        #DRIVE;
        regWrite  = 1'b0;
        // released data is scrambled so a stale word cannot pass
        regWrData = ~d;
    endtask

    task automatic readReg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock);
        #DRIVE;
        regAddr = a;
        @(posedge clock);
        #DRIVE;
        d = regRdData;
    endtask
endmodule

// ### verification/adc_limit_checker_bench.sv
`timescale 1ns/1ps
`include "limit_defines.svh"
module adc_limit_checker_bench;
    localparam int DRIVE = 5;
    localparam int LIMIT = 3000;

    logic        clock;
    logic        reset;
    logic        convValid;
    logic [3:0]  convChannel;
    logic [11:0] convResult;
    logic        alertPinEnable;
    logic        alertFlagEnable;
    logic [1:0]  currentOverrangeInput;
    logic [1:0]  diodeOpenInput;
    logic        regWrite;
    logic [7:0]  regAddr;
    logic [15:0] regWrData;
    logic [15:0] regRdData;
    logic        alertPin;
    logic        alertFlag;
    int          failCount;
    int          checks;
    int          cycles;
    logic [15:0] expWord;

    ////////////////////////////////////////////////////////////
    adc_limit_checker adc_limit_checker_i (
        .clock                 (clock),
        .reset                 (reset),
        .convValid             (convValid),
        .convChannel           (convChannel),
        .convResult            (convResult),
        .alertPinEnable        (alertPinEnable),
        .alertFlagEnable       (alertFlagEnable),
        .currentOverrangeInput (currentOverrangeInput),
        .diodeOpenInput        (diodeOpenInput),
        .regWrite              (regWrite),
        .regAddr               (regAddr),
        .regWrData             (regWrData),
        .regRdData             (regRdData),
        .alertPin              (alertPin),
        .alertFlag             (alertFlag)
    );

    limit_host #(.DRIVE(DRIVE)) limit_host_i (
        .clock     (clock),
        .regWrite  (regWrite),
        .regAddr   (regAddr),
        .regWrData (regWrData),
        .regRdData (regRdData)
    );

    ////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
    end

    always #50 clock = ~clock;

    // a hang still reaches the closing report
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            failCount++;
            testDone();
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic testDone();
        if (failCount == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failCount++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] chanAddr(input int ch,
                                            input logic [1:0] kind);
        return 8'h40 + 8'(ch * 4) + {6'h00, kind};
    endfunction

    task automatic expectReg(input string what, input logic [7:0] a,
                             input logic [15:0] exp);
        logic [15:0] d;
        limit_host_i.readReg(a, d);
        check(what, d, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        limit_host_i.writeReg(a, d);
    endtask

    task automatic convert(input logic [3:0] ch, input logic [11:0] res);
        @(posedge clock);
        #DRIVE;
        convValid   = 1'b1;
        convChannel = ch;
        convResult  = res;
        @(posedge clock);
        #DRIVE;
        convValid  = 1'b0;
        convResult = ~res;
    endtask

    // pins are registered behind the status, so one edge is let pass
    task automatic expectPins(input logic pin, input logic flag);
        @(posedge clock);
        #DRIVE;
        check("alertPin", {15'h0000, alertPin}, {15'h0000, pin});
        check("alertFlag", {15'h0000, alertFlag}, {15'h0000, flag});
    endtask

    ////////////////////////////////////////////////////////////
    initial
    begin
        failCount             = 0;
        checks                = 0;
        cycles                = 0;
        reset                 = 1'b1;
        convValid             = 1'b0;
        convChannel           = 4'h0;
        convResult            = 12'h000;
        alertPinEnable        = 1'b1;
        alertFlagEnable       = 1'b1;
        currentOverrangeInput = 2'h0;
        diodeOpenInput        = 2'h0;
        repeat (16) @(posedge clock);
        #DRIVE;
        reset = 1'b0;
        for (int ch = 0; ch < `NUM_CHAN; ch++)
        begin
            expectReg("upper", chanAddr(ch, `KIND_UPPER), 16'h0FFF);
            // diode channels show the good-diode bit on top
            expWord = (ch >= `FIRST_TEMP_CHAN &&
                       ch < `FIRST_TEMP_CHAN + `NUM_DIODE) ? 16'h0800 : 16'h0;
            expectReg("lower", chanAddr(ch, `KIND_LOWER), expWord);
            expWord = (ch < `FIRST_TEMP_CHAN) ? 16'h0008 : 16'h0020;
            expectReg("hyst", chanAddr(ch, `KIND_HYST), expWord);
        end
        for (int a = 4; a < 7; a++)
            expectReg("status", 8'(a), 16'h0000);
        wr(8'h07, 16'hFFFF);
        expectReg("unmapped", 8'h07, 16'h0000);
        // upper limit with default margin of 8 codes
        wr(chanAddr(0, `KIND_UPPER), 16'h0800);
        convert(4'h0, 12'h800);
        expectReg("equalUpper", `ADDR_STATUS_A, 16'h0000);
        convert(4'h0, 12'h801);
        expectReg("aboveUpper", `ADDR_STATUS_A, 16'h0002);
        expectPins(1'b1, 1'b1);
        convert(4'h0, 12'h7F9);
        expectReg("insideMargin", `ADDR_STATUS_A, 16'h0002);
        convert(4'h0, 12'h7F8);
        expectReg("backInRange", `ADDR_STATUS_A, 16'h0000);
        expectPins(1'b0, 1'b0);
        // same margin serves the lower limit
        wr(chanAddr(0, `KIND_LOWER), 16'h0100);
        convert(4'h0, 12'h0FF);
        expectReg("belowLower", `ADDR_STATUS_A, 16'h0001);
        convert(4'h0, 12'h107);
        expectReg("lowMargin", `ADDR_STATUS_A, 16'h0001);
        convert(4'h0, 12'h108);
        expectReg("lowRelease", `ADDR_STATUS_A, 16'h0000);
        // two channels accumulate, then enables and clears
        wr(chanAddr(1, `KIND_LOWER), 16'h0100);
        convert(4'h1, 12'h0FF);
        convert(4'h0, 12'h801);
        expectReg("accumulate", `ADDR_STATUS_A, 16'h0006);
        alertFlagEnable = 1'b0;
        expectPins(1'b1, 1'b0);
        alertPinEnable  = 1'b0;
        alertFlagEnable = 1'b1;
        expectPins(1'b0, 1'b1);
        alertPinEnable = 1'b1;
        wr(`ADDR_STATUS_A, 16'h0004);
        expectReg("clearOne", `ADDR_STATUS_A, 16'h0002);
        wr(`ADDR_STATUS_A, 16'h00FF);
        expectReg("clearAll", `ADDR_STATUS_A, 16'h0000);
        expectPins(1'b0, 1'b0);
        // margin wider than the upper limit holds the alert
        wr(chanAddr(2, `KIND_HYST), 16'h077D);
        wr(chanAddr(2, `KIND_UPPER), 16'h0700);
        convert(4'h2, 12'h701);
        convert(4'h2, 12'h000);
        expectReg("stuckAlert", `ADDR_STATUS_A, 16'h0020);
        wr(`ADDR_STATUS_A, 16'h00FF);
        // min/max recorder
        wr(chanAddr(3, `KIND_HYST), 16'h0FFF);
        wr(chanAddr(3, `KIND_UPPER), 16'h0000);
        wr(chanAddr(3, `KIND_LOWER), 16'h0FFF);
        convert(4'h3, 12'h400);
        convert(4'h3, 12'h300);
        convert(4'h3, 12'h500);
        convert(4'h3, 12'h400);
        expectReg("maxSeen", chanAddr(3, `KIND_UPPER), 16'h0500);
        expectReg("minSeen", chanAddr(3, `KIND_LOWER), 16'h0300);
        expectReg("noAlert", `ADDR_STATUS_A, 16'h0000);
        // overrange stays until written off, an in-range result is no cure
        for (int i = 0; i < 2; i++)
        begin
            currentOverrangeInput = 2'(1 << i);
            repeat (5) @(posedge clock);
            #DRIVE;
            currentOverrangeInput = 2'h0;
            repeat (5) @(posedge clock);
            convert(4'(4 + i), 12'h800);
            expWord = 16'(16'h0010 << i);
            expectReg("overrange", `ADDR_STATUS_B, expWord);
            wr(`ADDR_STATUS_B, expWord);
            expectReg("ovrCleared", `ADDR_STATUS_B, 16'h0000);
        end
        // open diode on the first remote channel
        diodeOpenInput = 2'h1;
        repeat (5) @(posedge clock);
        expectReg("openUpper", chanAddr(6, `KIND_UPPER), 16'h07FF);
        expectReg("openLower", chanAddr(6, `KIND_LOWER), 16'h0000);
        expectReg("goodUpper", chanAddr(7, `KIND_UPPER), 16'h0FFF);
        expectReg("openStatus", `ADDR_STATUS_C, 16'h0080);
        testDone();
    end
endmodule
